/* File: rtl/pin_ctrl_pkg.sv */
package pin_ctrl_pkg;
   // Byte offsets on the register bus
   localparam logic [7:0] REG_DOUT   = 8'h00;
   localparam logic [7:0] REG_DIR    = 8'h04;
   localparam logic [7:0] REG_OD     = 8'h08;
   localparam logic [7:0] REG_PU     = 8'h0c;
   localparam logic [7:0] REG_PD     = 8'h10;
   localparam logic [7:0] REG_DEB    = 8'h14;
   localparam logic [7:0] REG_LVL    = 8'h18;
   localparam logic [7:0] REG_RISE   = 8'h1c;
   localparam logic [7:0] REG_FALL   = 8'h20;
   localparam logic [7:0] REG_IEN    = 8'h24;
   localparam logic [7:0] REG_FLAG   = 8'h28;
   localparam logic [7:0] REG_PIN    = 8'h2c;
   localparam logic [7:0] REG_AEN    = 8'h30;
   localparam logic [7:0] REG_PINCFG = 8'h40;
   // Pin configuration word fields
   localparam int SEL_W    = 3;
   localparam int DRV_W    = 3;
   localparam int FSEL_LSB = 0;
   localparam int DRV_LSB  = 4;
   localparam int NSEL     = 8;
   localparam logic [SEL_W-1:0] FSEL_GPIO = 3'h0;
   localparam int BYTE_W   = 8;
   localparam int NBYTES   = 4;
endpackage : pin_ctrl_pkg

/* File: rtl/pin_ctrl.sv */
// Operation
// - Per pin: push-pull, open-drain, or input
// - Per pin weak pull-up and pull-down enables
// - Per pin switchable input debounce filter
// - Per pin drive strength setting
// - Every pin interrupts; level or edge mode
// - Edge trigger: rising, falling or both
// - Separate interrupt enable and flag per pin
// - Eight-way function selector per pin
// - Analog mode bypasses the function multiplexer
// - Selector zero is GPIO; analog pins link
//
// The implementer's own choices: the Wishbone register port and the register offsets.
module pin_ctrl
   import pin_ctrl_pkg::*;
#(
   parameter int              NPINS       = 15,
   parameter int              DEB_CYCLES  = 4,
   parameter logic [NPINS-1:0] ANALOG_MASK = 15'h7800
) (
   // Clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rstn_i,
   input  wire logic                    ce_i,
   // Wishbone slave
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [31:0]             wb_dat_i,
   input  wire logic [3:0]              wb_sel_i,
   output      logic [31:0]             wb_dat_o,
   output      logic                    wb_ack_o,
   // Pads
   input  wire logic [NPINS-1:0]        pad_i,
   output      logic [NPINS-1:0]        pad_o,
   output      logic [NPINS-1:0]        pad_oe_o,
   output      logic [NPINS-1:0]        pull_up_o,
   output      logic [NPINS-1:0]        pull_dn_o,
   output      logic [NPINS*DRV_W-1:0]  drive_o,
   // Peripheral functions, slot s of pin p at index p*NSEL+s
   input  wire logic [NPINS*NSEL-1:0]   func_out_i,
   input  wire logic [NPINS*NSEL-1:0]   func_oe_i,
   output      logic [NPINS*NSEL-1:0]   func_in_o,
   output      logic [NPINS-1:0]        analog_channel_link_o,
   // Interrupt
   output      logic                    irq_o
);

   localparam int CW = $clog2(DEB_CYCLES + 1);
   localparam logic [CW-1:0] DEB_LAST = CW'(DEB_CYCLES - 1);

   // Every check runs on the bus clock and sleeps through reset
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   typedef struct packed {
      logic                              ack;
      logic [31:0]                       rdat;
      logic [NPINS-1:0]                  dout;
      logic [NPINS-1:0]                  dir;
      logic [NPINS-1:0]                  od;
      logic [NPINS-1:0]                  pu;
      logic [NPINS-1:0]                  pd;
      logic [NPINS-1:0]                  deb;
      logic [NPINS-1:0]                  lvl;
      logic [NPINS-1:0]                  rise;
      logic [NPINS-1:0]                  fall;
      logic [NPINS-1:0]                  ien;
      logic [NPINS-1:0]                  flag;
      logic [NPINS-1:0]                  aen;
      logic [NPINS-1:0]                  filt;
      logic [NPINS-1:0]                  prev;
      logic [NPINS-1:0][SEL_W-1:0]       fsel;
      logic [NPINS-1:0][DRV_W-1:0]       drv;
      logic [NPINS-1:0][CW-1:0]          cnt;
   } state_t;

   state_t           r_reg;
   state_t           r_next;
   logic             req;
   logic [NPINS-1:0] clr;
   logic [NPINS-1:0] ev;

   // Byte-lane merge of a write into a pin-wide register
   function automatic logic [NPINS-1:0] upd(input logic [NPINS-1:0] o);
      logic [31:0] m;
      m = 32'(o);
      for (int b = 0; b < NBYTES; b++) begin
         if (wb_sel_i[b]) begin
            m[b*BYTE_W +: BYTE_W] = wb_dat_i[b*BYTE_W +: BYTE_W];
         end
      end
      return m[NPINS-1:0];
   endfunction : upd

   always_comb begin
      int idx;
      idx    = 0;
      r_next = r_reg;
      req    = wb_cyc_i & wb_stb_i & ~r_reg.ack;
      clr    = '0;
      r_next.ack = req;
      if (wb_adr_i >= REG_PINCFG) begin
         idx = int'(wb_adr_i - REG_PINCFG) / NBYTES;
      end
      // Register writes
      if (req && wb_we_i) begin
         if (wb_adr_i == REG_DOUT) begin
            r_next.dout = upd(r_reg.dout);
         end else if (wb_adr_i == REG_DIR) begin
            r_next.dir = upd(r_reg.dir);
         end else if (wb_adr_i == REG_OD) begin
            r_next.od = upd(r_reg.od);
         end else if (wb_adr_i == REG_PU) begin
            r_next.pu = upd(r_reg.pu);
         end else if (wb_adr_i == REG_PD) begin
            r_next.pd = upd(r_reg.pd);
         end else if (wb_adr_i == REG_DEB) begin
            r_next.deb = upd(r_reg.deb);
         end else if (wb_adr_i == REG_LVL) begin
            r_next.lvl = upd(r_reg.lvl);
         end else if (wb_adr_i == REG_RISE) begin
            r_next.rise = upd(r_reg.rise);
         end else if (wb_adr_i == REG_FALL) begin
            r_next.fall = upd(r_reg.fall);
         end else if (wb_adr_i == REG_IEN) begin
            r_next.ien = upd(r_reg.ien);
         end else if (wb_adr_i == REG_FLAG) begin
            clr = upd('0);
         end else if (wb_adr_i == REG_AEN) begin
            r_next.aen = upd(r_reg.aen) & ANALOG_MASK;
         end else if (idx < NPINS && wb_adr_i[1:0] == 2'h0
                      && wb_sel_i[0]) begin
            r_next.fsel[idx] = wb_dat_i[FSEL_LSB +: SEL_W];
            r_next.drv[idx]  = wb_dat_i[DRV_LSB +: DRV_W];
         end
      end
      // Register reads; unmapped words read zero, except 0x34 to 0x3c, which read pin 0's config word
      if (req) begin
         r_next.rdat = '0;
         if (wb_adr_i == REG_DOUT) begin
            r_next.rdat = 32'(r_reg.dout);
         end else if (wb_adr_i == REG_DIR) begin
            r_next.rdat = 32'(r_reg.dir);
         end else if (wb_adr_i == REG_OD) begin
            r_next.rdat = 32'(r_reg.od);
         end else if (wb_adr_i == REG_PU) begin
            r_next.rdat = 32'(r_reg.pu);
         end else if (wb_adr_i == REG_PD) begin
            r_next.rdat = 32'(r_reg.pd);
         end else if (wb_adr_i == REG_DEB) begin
            r_next.rdat = 32'(r_reg.deb);
         end else if (wb_adr_i == REG_LVL) begin
            r_next.rdat = 32'(r_reg.lvl);
         end else if (wb_adr_i == REG_RISE) begin
            r_next.rdat = 32'(r_reg.rise);
         end else if (wb_adr_i == REG_FALL) begin
            r_next.rdat = 32'(r_reg.fall);
         end else if (wb_adr_i == REG_IEN) begin
            r_next.rdat = 32'(r_reg.ien);
         end else if (wb_adr_i == REG_FLAG) begin
            r_next.rdat = 32'(r_reg.flag);
         end else if (wb_adr_i == REG_PIN) begin
            r_next.rdat = 32'(r_reg.filt);
         end else if (wb_adr_i == REG_AEN) begin
            r_next.rdat = 32'(r_reg.aen);
         end else if (idx < NPINS && wb_adr_i[1:0] == 2'h0) begin
            r_next.rdat[FSEL_LSB +: SEL_W] = r_reg.fsel[idx];
            r_next.rdat[DRV_LSB +: DRV_W]  = r_reg.drv[idx];
         end
      end
      // Input filter: a change must persist DEB_CYCLES clocks
      for (int p = 0; p < NPINS; p++) begin
         if (!r_reg.deb[p] || pad_i[p] == r_reg.filt[p]) begin
            r_next.cnt[p]  = '0;
            r_next.filt[p] = pad_i[p];
         end else if (r_reg.cnt[p] == DEB_LAST) begin
            r_next.cnt[p]  = '0;
            r_next.filt[p] = pad_i[p];
         end else begin
            r_next.cnt[p]  = r_reg.cnt[p] + CW'(1);
         end
      end
      r_next.prev = r_reg.filt;
      // Level mode: rise selects high, fall selects low
      ev = r_reg.lvl & ((r_reg.rise & r_reg.filt)
                        | (r_reg.fall & ~r_reg.filt));
      ev = ev | (~r_reg.lvl & ((r_reg.rise & r_reg.filt & ~r_reg.prev)
                 | (r_reg.fall & ~r_reg.filt & r_reg.prev)));
      // A new event wins over a clear in the same cycle
      r_next.flag = (r_reg.flag & ~clr) | ev;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r_reg <= '0;
      end else if (ce_i) begin
         r_reg <= r_next;
      end
   end

   assign wb_ack_o = r_reg.ack;
   assign wb_dat_o = r_reg.rdat;
   assign irq_o    = |(r_reg.flag & r_reg.ien);

   // Pull enables pass through as written outside analog mode; both on is left to software
   assign analog_channel_link_o = r_reg.aen & ANALOG_MASK;

   for (genvar p = 0; p < NPINS; p++) begin : g_pin
      logic o_val;
      logic o_en;
      always_comb begin
         if (r_reg.fsel[p] == FSEL_GPIO) begin
            o_val = r_reg.dout[p];
            o_en  = r_reg.dir[p];
         end else begin
            o_val = func_out_i[p*NSEL + int'(r_reg.fsel[p])];
            o_en  = func_oe_i[p*NSEL + int'(r_reg.fsel[p])];
         end
      end
      // Open drain never drives high: it releases instead
      assign pad_o[p]    = o_val & ~r_reg.od[p];
      assign pad_oe_o[p] = o_en & ~r_reg.aen[p]
                           & ~(r_reg.od[p] & o_val);
      // Pulls would load an analog source, so analog mode drops them
      assign pull_up_o[p] = r_reg.pu[p] & ~r_reg.aen[p];
      assign pull_dn_o[p] = r_reg.pd[p] & ~r_reg.aen[p];
      assign drive_o[p*DRV_W +: DRV_W] = r_reg.drv[p];
      for (genvar s = 0; s < NSEL; s++) begin : g_sel
         assign func_in_o[p*NSEL+s] = r_reg.filt[p] & ~r_reg.aen[p]
            & (r_reg.fsel[p] == SEL_W'(s));
      end


      // Pin checks: drive, routing, filter, then flags
      chk_od_no_high: assert property (r_reg.od[p] |-> !pad_o[p])
         else $error("open drain pin drives high");
      chk_pp_drive: assert property ((r_reg.fsel[p] == FSEL_GPIO
         && r_reg.dir[p] && !r_reg.od[p] && !r_reg.aen[p])
         |-> pad_oe_o[p] && pad_o[p] == r_reg.dout[p])
         else $error("gpio push-pull output wrong");
      chk_input_mode: assert property ((r_reg.fsel[p] == FSEL_GPIO
         && !r_reg.dir[p]) |-> !pad_oe_o[p])
         else $error("input pin drives its pad");
      chk_analog_off: assert property (r_reg.aen[p]
         |-> !pad_oe_o[p] && !func_in_o[p*NSEL])
         else $error("analog pin not bypassed");
      chk_pull_analog: assert property (r_reg.aen[p]
         |-> !pull_up_o[p] && !pull_dn_o[p])
         else $error("pull left on in analog mode");
      chk_func_route: assert property (!r_reg.aen[p]
         |-> func_in_o[p*NSEL + int'(r_reg.fsel[p])] == r_reg.filt[p])
         else $error("selected function misses the input");
      chk_deb_bypass: assert property (ce_i && !r_reg.deb[p]
         |=> r_reg.filt[p] == $past(pad_i[p]))
         else $error("filter off but input delayed");
      // A one-sample filter lets every change through at once
      chk_deb_hold: assert property (DEB_CYCLES > 1 && ce_i
         && r_reg.deb[p] && r_reg.cnt[p] == '0
         && pad_i[p] != r_reg.filt[p]
         |=> $stable(r_reg.filt[p]))
         else $error("filter passed a glitch");
      chk_level_high: assert property (ce_i && r_reg.lvl[p]
         && r_reg.rise[p] && r_reg.filt[p] |=> r_reg.flag[p])
         else $error("high level not flagged");
      chk_level_low: assert property (ce_i && r_reg.lvl[p]
         && r_reg.fall[p] && !r_reg.filt[p] |=> r_reg.flag[p])
         else $error("low level not flagged");
      chk_prev_follow: assert property (ce_i
         |=> r_reg.prev[p] == $past(r_reg.filt[p]))
         else $error("edge history does not lag filter");
      chk_edge_rise: assert property (ce_i && !r_reg.lvl[p]
         && r_reg.rise[p] && r_reg.filt[p] && !r_reg.prev[p]
         |=> r_reg.flag[p])
         else $error("rising edge not flagged");
      chk_edge_fall: assert property (ce_i && !r_reg.lvl[p]
         && r_reg.fall[p] && !r_reg.filt[p] && r_reg.prev[p]
         |=> r_reg.flag[p])
         else $error("falling edge not flagged");
      chk_flag_sticky: assert property (ce_i && r_reg.flag[p]
         && !(req && wb_we_i && wb_adr_i == REG_FLAG)
         |=> r_reg.flag[p])
         else $error("flag lost without clear");
      chk_flag_clear: assert property (ce_i && clr[p] && !ev[p]
         |=> !r_reg.flag[p])
         else $error("flag not cleared by write");
   end

   chk_irq_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
      irq_o == |(r_reg.flag & r_reg.ien))
      else $error("interrupt not gated by enable");
   // Bus answers one cycle after a taken request, for one cycle only
   chk_ack_answer: assert property (@(posedge clk_i) disable iff (!rstn_i)
      ce_i && req |=> wb_ack_o)
      else $error("bus request not answered");
   chk_ack_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_ce_freeze: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !ce_i |=> $stable(r_reg))
      else $error("state moved while clock enable low");

endmodule : pin_ctrl

/* File: bench/pin_far_side.sv */
module pin_far_side
   import pin_ctrl_pkg::*;
#(
   parameter int NPINS = 15
) (
   // Clock
   input  wire logic                  clk_i,
   // Block side
   input  wire logic [NPINS-1:0]      pad_o,
   input  wire logic [NPINS-1:0]      pad_oe_o,
   input  wire logic [NPINS-1:0]      pull_up_o,
   input  wire logic [NPINS-1:0]      pull_dn_o,
   // Outside driver
   input  wire logic [NPINS-1:0]      ext_val_i,
   input  wire logic [NPINS-1:0]      ext_en_i,
   // Resolved pads and peripherals
   output      logic [NPINS-1:0]      pad_i,
   output      logic [NPINS*NSEL-1:0] func_out_i,
   output      logic [NPINS*NSEL-1:0] func_oe_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NPINS-1:0] last_reg = '0;
   always_ff @(posedge clk_i) last_reg <= pad_i;
   // A floating pad shows the inverse of its last level, never a stale copy
   always_comb begin
      for (int p = 0; p < NPINS; p++) begin
         if (pad_oe_o[p]) pad_i[p] = pad_o[p];
         else if (ext_en_i[p]) pad_i[p] = ext_val_i[p];
         else if (pull_up_o[p]) pad_i[p] = 1'b1;
         else if (pull_dn_o[p]) pad_i[p] = 1'b0;
         else pad_i[p] = ~last_reg[p];
      end
   end
   // Kept apart so the peripheral side never loops through the pads
   always_comb begin
      for (int p = 0; p < NPINS; p++) begin
         for (int s = 0; s < NSEL; s++) func_out_i[p*NSEL+s] = s[0];
      end
      func_oe_i = '1;
   end
endmodule : pin_far_side

/* File: bench/io_pin_controller_with_mux_tb.sv */
module io_pin_controller_with_mux_tb;
   import pin_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NP = 15;
   typedef struct packed {logic pad; logic [7:0] fin;} row_t;
   row_t rows [8] = '{'{1'b1, 8'h01}, '{1'b1, 8'h02}, '{1'b0, 8'h00},
      '{1'b1, 8'h08}, '{1'b0, 8'h00}, '{1'b1, 8'h20}, '{1'b0, 8'h00},
      '{1'b1, 8'h80}};
   logic clk_i = 0, rstn_i = 0, cyc = 0, stb = 0, we = 0, ack, irq;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, rdat, q;
   logic [NP-1:0] pad_i, pad_o, pad_oe, pu, pd, link;
   logic [NP-1:0] ext_val = '0, ext_en = '1;
   logic [NP*DRV_W-1:0] drv;
   logic [NP*NSEL-1:0] fo, foe, fin;
   int n_mismatch = 0, total_checks = 0;
   always #5 clk_i = ~clk_i;
   pin_ctrl #(.NPINS(NP), .DEB_CYCLES(2)) dut (.clk_i(clk_i),
      .rstn_i(rstn_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf),
      .wb_dat_o(rdat), .wb_ack_o(ack), .pad_i(pad_i), .pad_o(pad_o),
      .pad_oe_o(pad_oe), .pull_up_o(pu), .pull_dn_o(pd), .drive_o(drv),
      .func_out_i(fo), .func_oe_i(foe), .func_in_o(fin),
      .analog_channel_link_o(link), .irq_o(irq));
   pin_far_side #(.NPINS(NP)) far (.clk_i(clk_i), .pad_o(pad_o),
      .pad_oe_o(pad_oe), .pull_up_o(pu), .pull_dn_o(pd), .ext_val_i(ext_val),
      .ext_en_i(ext_en), .pad_i(pad_i), .func_out_i(fo), .func_oe_i(foe));
   task finish_test;
      if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : finish_test
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Classic cycle: hold everything until ack is seen at a rising edge
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1);
      q = rdat;
      chk("ack_lat", 32'h2, 32'(n));
      cyc <= 1'b0; stb <= 1'b0;
   endtask : wb
   task rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask : rd
   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : tick
   task pad3(input logic v, input int n);
      @(posedge clk_i);
      ext_val[3] <= v;
      tick(n);
   endtask : pad3
   initial begin
      #100us;
      n_mismatch++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      chk("oe_rst", 32'h0, pad_oe); chk("irq_rst", 32'h0, irq);
      rd("dir_rst", REG_DIR, 32'h0);
      rd("unmapped", 8'h3c, 32'h0);
      wb(1'b1, REG_DIR, 32'h1); wb(1'b1, REG_DOUT, 32'h1);
      foreach (rows[s]) begin
         wb(1'b1, REG_PINCFG, 32'(s) | (32'(7 - s) << DRV_LSB));
         tick(4);
         chk("pad0", 32'(rows[s].pad), 32'(pad_o[0]));
         chk("fin0", 32'(rows[s].fin), 32'(fin[7:0]));
         chk("drv0", 32'(7 - s), 32'(drv[2:0]));
      end
      wb(1'b1, REG_DIR, 32'h2); wb(1'b1, REG_OD, 32'h2);
      wb(1'b1, REG_DOUT, 32'h0); tick(1);
      chk("od_low", 32'h4, {pad_oe[1], pad_o[1], 1'b0});
      wb(1'b1, REG_DOUT, 32'h2); tick(1);
      chk("od_high", 32'h0, 32'(pad_oe[1]));
      wb(1'b1, REG_DIR, 32'h0); tick(1);
      // Pin 0 still sits on slot 7, whose peripheral drives it
      chk("input", 32'h1, pad_oe);
      wb(1'b1, REG_PU, 32'h0804); tick(1);
      chk("pu", 32'h0804, pu); chk("pd0", 32'h0, pd);
      wb(1'b1, REG_PU, 32'h0); wb(1'b1, REG_PD, 32'h4); tick(1);
      chk("pd", 32'h4, pd); chk("pu0", 32'h0, pu);
      wb(1'b1, REG_PU, 32'h0800); wb(1'b1, REG_PINCFG + 8'h2c, 32'h1);
      wb(1'b1, REG_AEN, 32'h7801); tick(2);
      chk("link", 32'h7800, link);
      chk("afin", 32'h0, fin[11*NSEL +: NSEL]);
      chk("apu", 32'h0, pu);
      wb(1'b1, REG_IEN, 32'h8);
      for (int m = 1; m < 4; m++) begin
         wb(1'b1, REG_RISE, 32'(m[0]) << 3);
         wb(1'b1, REG_FALL, 32'(m[1]) << 3);
         wb(1'b1, REG_FLAG, 32'hffff);
         pad3(1'b1, 4);
         chk("irq_r", 32'(m[0]), 32'(irq));
         rd("flag_r", REG_FLAG, 32'(m[0]) << 3);
         wb(1'b1, REG_FLAG, 32'h8);
         pad3(1'b0, 4);
         rd("flag_f", REG_FLAG, 32'(m[1]) << 3);
         wb(1'b1, REG_FLAG, 32'h8);
      end
      wb(1'b1, REG_DEB, 32'h8); wb(1'b1, REG_RISE, 32'h8);
      wb(1'b1, REG_FALL, 32'h0); wb(1'b1, REG_FLAG, 32'h8);
      pad3(1'b1, 0); pad3(1'b0, 6);
      rd("glitch", REG_FLAG, 32'h0);
      pad3(1'b1, 8);
      rd("deb_ok", REG_FLAG, 32'h8);
      rd("pin", REG_PIN, 32'h9);
      wb(1'b1, REG_LVL, 32'h8); wb(1'b1, REG_FLAG, 32'h8); tick(2);
      rd("lvl_hold", REG_FLAG, 32'h8);
      wb(1'b1, REG_IEN, 32'h0); tick(1);
      chk("irq_mask", 32'h0, 32'(irq));
      pad3(1'b0, 8); wb(1'b1, REG_FLAG, 32'h8);
      rd("lvl_clr", REG_FLAG, 32'h0);
      wb(1'b1, REG_RISE, 32'h0); wb(1'b1, REG_FALL, 32'h8);
      wb(1'b1, REG_FLAG, 32'h8);
      rd("lvl_low", REG_FLAG, 32'h8);
      @(posedge clk_i);
      rstn_i <= 1'b0;
      tick(1);
      chk("oe_mid", 32'h1 & 32'h0, pad_oe); chk("link_mid", 32'h0, link);
      chk("irq_mid", 32'h0, irq);
      @(posedge clk_i);
      rstn_i <= 1'b1;
      rd("flag_mid", REG_FLAG, 32'h0);
      rd("cfg_mid", REG_PINCFG, 32'h0);
      finish_test();
   end
endmodule : io_pin_controller_with_mux_tb
